// *** design/sqwt_pkg.sv ***
// Package for the square-wave timer unit: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package sqwt_pkg;
    localparam int SQWT_NCH = 8;
    localparam int SQWT_CNT_W = 16;
    localparam int SQWT_PRE_W = 4;
    // Register byte offsets
    localparam logic [7:0] SQWT_OFS_PERIPH_EN = 8'h00;
    localparam logic [7:0] SQWT_OFS_START = 8'h04;
    localparam logic [7:0] SQWT_OFS_STOP = 8'h08;
    localparam logic [7:0] SQWT_OFS_ENABLED = 8'h0C;
    localparam logic [7:0] SQWT_OFS_OUT_LEVEL = 8'h10;
    localparam logic [7:0] SQWT_OFS_OUT_EN = 8'h14;
    localparam logic [7:0] SQWT_OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] SQWT_OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] SQWT_OFS_CH_BASE = 8'h40;
    // Per channel: mode at base + 16*n, compare data at +4, count value at +8
    localparam logic [7:0] SQWT_OFS_CH_MODE = 8'h00;
    localparam logic [7:0] SQWT_OFS_CH_DATA = 8'h04;
    localparam logic [7:0] SQWT_OFS_CH_COUNT = 8'h08;
    // Field positions
    localparam int SQWT_BIT_UNIT_CLK_EN = 0;
    localparam int SQWT_BIT_START_IRQ_SEL = 0;
    localparam int SQWT_POS_CLK_SEL = 4;
    localparam int SQWT_POS_PRESCALE = 8;
    // Reset values
    localparam logic [SQWT_CNT_W-1:0] SQWT_RST_DATA = 16'h0000;
    localparam logic [SQWT_CNT_W-1:0] SQWT_RST_COUNT = 16'hFFFF;
    localparam logic [31:0] SQWT_RST_MODE = 32'h0000_0000;
    localparam logic [1:0] SQWT_RESP_OKAY = 2'b00;
    localparam logic [1:0] SQWT_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {SQWT_CLK_SYS, SQWT_CLK_SUB, SQWT_CLK_LOW} sqwt_clksel_t;

    typedef struct packed {
        logic [SQWT_CNT_W-1:0] data;
        logic [SQWT_PRE_W-1:0] prescale;
        sqwt_clksel_t clk_sel;
        logic start_irq_sel;
    } sqwt_chcfg_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic run_en;
    } sqwt_chctl_t;

    typedef struct packed {
        logic running;
        logic toggle;
        logic irq;
        logic [SQWT_CNT_W-1:0] count;
    } sqwt_chst_t;
endpackage : sqwt_pkg

// *** design/sqwt_prescaler.sv ***
// Prescaler: one-cycle tick at CLK_SYS / 2^k for k = 0..15.
// Assumes the counter is frozen while the unit clock supply is off.
`timescale 1ns/1ps
module sqwt_prescaler
    import sqwt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic enable,
    // Ticks, index k = divide by 2^k
    output logic [15:0] ticks
);
    logic [14:0] div_reg;
    logic [14:0] div_next;
    logic [15:0] roll;

    assign div_next = enable ? div_reg + 15'h0001 : div_reg;
    // Bit k+1 tick whenever the low k+1 bits roll over to zero
    assign roll[0] = enable;
    genvar g;
    generate
        for (g = 1; g < 16; g++) begin : g_tick
            assign roll[g] = enable && (div_next[g-1:0] == '0);
        end
    endgenerate
    assign ticks = roll;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= 15'h0000;
        end else begin
            div_reg <= div_next;
        end
    end
endmodule : sqwt_prescaler

// *** design/sqwt_channel.sv ***
// One down-counting square-wave channel.
// Assumes cnt_tick is a one-cycle pulse on the selected count clock.
`timescale 1ns/1ps
module sqwt_channel
    import sqwt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire sqwt_chcfg_t cfg,
    input wire sqwt_chctl_t ctl,
    input wire logic cnt_tick,
    // Status
    output sqwt_chst_t st
);
    logic running_reg;
    logic [SQWT_CNT_W-1:0] count_reg;
    logic [SQWT_CNT_W-1:0] count_next;
    logic zero_irq;
    logic start_go;
    logic irq;

    assign start_go = ctl.start && ctl.run_en;
    assign zero_irq = running_reg && ctl.run_en && cnt_tick && (count_reg == '0);
    assign irq = zero_irq || (start_go && cfg.start_irq_sel);
    // Reload on start and at each period end
    assign count_next = (start_go || zero_irq) ? cfg.data
        : (running_reg && ctl.run_en && cnt_tick) ? count_reg - 16'h0001 : count_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            running_reg <= 1'b0;
            count_reg <= SQWT_RST_COUNT;
        end else begin
            if (start_go) begin
                running_reg <= 1'b1;
            end else if (ctl.stop) begin
                running_reg <= 1'b0;
            end
            count_reg <= count_next;
        end
    end

    assign st.running = running_reg;
    assign st.count = count_reg;
    assign st.irq = irq;
    // Toggle at every interrupt gives a 50% duty square wave of period 2*(data+1) ticks
    assign st.toggle = irq;
endmodule : sqwt_channel

// *** design/sqwt_unit.sv ***
// Square-wave timer unit: eight channels behind an AXI4-Lite slave.
// Assumes a 10 MHz CLK_SYS; sub and low-speed clocks arrive as synchronous tick strobes.
`timescale 1ns/1ps

// What this block does
// - Channel counts prescaled clock; sub and low-speed clock only on channel five.
// - Nothing runs until software sets the unit clock supply enable bit.
// - Output frequency is count clock over twice (compare data plus one).
// - Interrupt on the count clock pulse after the count reached zero.
// - With start interrupt select set, also interrupt when counting starts.
// - Writing one to the start trigger bit begins counting.
// - Writing one to the stop trigger bit halts; writing zero to start does not.
// - Counter loads compare data at start and at each interrupt.
// - Current count value is readable any time without disturbing counting.
// - Output enable zero makes the pin follow the software output level bit.
// - Start interrupt select one inverts output right after start from preset level.
// - Start interrupt select zero keeps preset level at start, toggling later.
// - Unit holds eight independent channels zero to seven; two units possible.
module sqwt_unit
    import sqwt_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Alternate count clock strobes, synchronous to CLK_SYS
    input wire logic SUB_TICK,
    input wire logic LOW_TICK,
    // AXI4-Lite write address
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Timer outputs and interrupt
    output logic [SQWT_NCH-1:0] TIMER_OUT,
    output logic IRQ
);
    // Write and read channel capture
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Registers
    logic unit_clk_en_reg;
    logic [SQWT_NCH-1:0] out_level_reg;
    logic [SQWT_NCH-1:0] out_en_reg;
    logic [SQWT_NCH-1:0] irq_stat_reg;
    logic [SQWT_NCH-1:0] irq_mask_reg;
    logic [31:0] mode_reg [SQWT_NCH];
    logic [SQWT_CNT_W-1:0] data_reg [SQWT_NCH];

    logic do_write;
    logic do_read;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [15:0] ticks;
    logic [SQWT_NCH-1:0] start_pulse;
    logic [SQWT_NCH-1:0] stop_pulse;
    logic [SQWT_NCH-1:0] ch_running;
    logic [SQWT_NCH-1:0] ch_irq;
    logic [SQWT_NCH-1:0] ch_toggle;
    logic [SQWT_NCH-1:0] stat_clear;
    sqwt_chst_t ch_st [SQWT_NCH];
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_val;

    // Channel register address decode, used for both reads and writes
    function automatic logic ch_hit(input logic [7:0] a, input logic [7:0] sub);
        return (a >= SQWT_OFS_CH_BASE) && (a[3:0] == sub[3:0])
            && (a < SQWT_OFS_CH_BASE + 8'(SQWT_NCH * 16));
    endfunction : ch_hit

    function automatic logic [2:0] ch_idx(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - SQWT_OFS_CH_BASE;
        return rel[6:4];
    endfunction : ch_idx

    function automatic logic glb_hit(input logic [7:0] a);
        return a <= SQWT_OFS_IRQ_MASK && a[1:0] == 2'b00;
    endfunction : glb_hit

    // AXI handshakes: accept each write half once, answer after both
    assign AWREADY = !aw_full_reg && !bvalid_reg;
    assign WREADY = !w_full_reg && !bvalid_reg;
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign ARREADY = !rvalid_reg;
    assign do_read = ARVALID && ARREADY;
    assign wa = awaddr_reg;
    assign ra = ARADDR;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;

    assign wr_ok = glb_hit(wa) || ch_hit(wa, SQWT_OFS_CH_MODE) || ch_hit(wa, SQWT_OFS_CH_DATA)
        || ch_hit(wa, SQWT_OFS_CH_COUNT);
    assign rd_ok = glb_hit(ra) || ch_hit(ra, SQWT_OFS_CH_MODE) || ch_hit(ra, SQWT_OFS_CH_DATA)
        || ch_hit(ra, SQWT_OFS_CH_COUNT);

    // Trigger registers are write-only strobes; a zero bit has no effect
    assign start_pulse = (do_write && wa == SQWT_OFS_START && unit_clk_en_reg && wstrb_reg[0])
        ? wdata_reg[SQWT_NCH-1:0] : '0;
    assign stop_pulse = (do_write && wa == SQWT_OFS_STOP && wstrb_reg[0])
        ? wdata_reg[SQWT_NCH-1:0] : '0;
    assign stat_clear = (do_read && ra == SQWT_OFS_IRQ_STAT) ? '1 : '0;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (ch_hit(ra, SQWT_OFS_CH_MODE)) begin
            rd_val = mode_reg[ch_idx(ra)];
        end else if (ch_hit(ra, SQWT_OFS_CH_DATA)) begin
            rd_val = {16'h0000, data_reg[ch_idx(ra)]};
        end else if (ch_hit(ra, SQWT_OFS_CH_COUNT)) begin
            rd_val = {16'h0000, ch_st[ch_idx(ra)].count};
        end else begin
            unique case (ra)
                SQWT_OFS_PERIPH_EN: rd_val = {31'h0, unit_clk_en_reg};
                SQWT_OFS_ENABLED: rd_val = {24'h0, ch_running};
                SQWT_OFS_OUT_LEVEL: rd_val = {24'h0, out_level_reg};
                SQWT_OFS_OUT_EN: rd_val = {24'h0, out_en_reg};
                SQWT_OFS_IRQ_STAT: rd_val = {24'h0, irq_stat_reg};
                SQWT_OFS_IRQ_MASK: rd_val = {24'h0, irq_mask_reg};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    sqwt_prescaler u_pre (
        .clk(CLK_SYS),
        .nrst(NRST),
        .enable(unit_clk_en_reg),
        .ticks(ticks)
    );

    genvar n;
    generate
        for (n = 0; n < SQWT_NCH; n++) begin : g_ch
            sqwt_chcfg_t cfg;
            sqwt_chctl_t ctl;
            logic tick;
            logic [1:0] sel;
            assign sel = mode_reg[n][SQWT_POS_CLK_SEL +: 2];
            assign cfg.data = data_reg[n];
            assign cfg.prescale = mode_reg[n][SQWT_POS_PRESCALE +: SQWT_PRE_W];
            assign cfg.start_irq_sel = mode_reg[n][SQWT_BIT_START_IRQ_SEL];
            // Alternate clocks exist on channel five only; others fall back to prescaler
            assign cfg.clk_sel = (n == 5 && sel == 2'd1) ? SQWT_CLK_SUB
                : (n == 5 && sel == 2'd2) ? SQWT_CLK_LOW : SQWT_CLK_SYS;
            assign tick = (cfg.clk_sel == SQWT_CLK_SUB) ? SUB_TICK && unit_clk_en_reg
                : (cfg.clk_sel == SQWT_CLK_LOW) ? LOW_TICK && unit_clk_en_reg
                : ticks[cfg.prescale];
            assign ctl.start = start_pulse[n];
            assign ctl.stop = stop_pulse[n];
            assign ctl.run_en = unit_clk_en_reg;
            sqwt_channel u_ch (
                .clk(CLK_SYS),
                .nrst(NRST),
                .cfg(cfg),
                .ctl(ctl),
                .cnt_tick(tick),
                .st(ch_st[n])
            );
            assign ch_running[n] = ch_st[n].running;
            assign ch_irq[n] = ch_st[n].irq;
            assign ch_toggle[n] = ch_st[n].toggle;
        end
    endgenerate

    // Pin shows the output latch; timer toggles it only while output enable is one
    assign TIMER_OUT = out_level_reg;
    assign IRQ = |(irq_stat_reg & irq_mask_reg);

    // Bus channel state
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= SQWT_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= SQWT_RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= AWADDR;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_full_reg <= 1'b1;
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? SQWT_RESP_OKAY : SQWT_RESP_SLVERR;
            end else if (BREADY) begin
                bvalid_reg <= 1'b0;
            end
            if (do_read) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_val;
                rresp_reg <= rd_ok ? SQWT_RESP_OKAY : SQWT_RESP_SLVERR;
            end else if (RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Software registers; the count register is read-only
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            unit_clk_en_reg <= 1'b0;
            out_en_reg <= '0;
            irq_mask_reg <= '0;
            for (int i = 0; i < SQWT_NCH; i++) begin
                mode_reg[i] <= SQWT_RST_MODE;
                data_reg[i] <= SQWT_RST_DATA;
            end
        end else if (do_write && wstrb_reg[0]) begin
            if (wa == SQWT_OFS_PERIPH_EN) begin
                unit_clk_en_reg <= wdata_reg[SQWT_BIT_UNIT_CLK_EN];
            end
            if (wa == SQWT_OFS_OUT_EN) begin
                out_en_reg <= wdata_reg[SQWT_NCH-1:0];
            end
            if (wa == SQWT_OFS_IRQ_MASK) begin
                irq_mask_reg <= wdata_reg[SQWT_NCH-1:0];
            end
            if (ch_hit(wa, SQWT_OFS_CH_MODE)) begin
                mode_reg[ch_idx(wa)] <= wdata_reg;
            end
            if (ch_hit(wa, SQWT_OFS_CH_DATA) && wstrb_reg[1]) begin
                data_reg[ch_idx(wa)] <= wdata_reg[SQWT_CNT_W-1:0];
            end
        end
    end

    // Output latch: software writes take effect only while timer output is disabled
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            out_level_reg <= '0;
        end else begin
            for (int i = 0; i < SQWT_NCH; i++) begin
                if (out_en_reg[i] && ch_toggle[i]) begin
                    out_level_reg[i] <= !out_level_reg[i];
                end else if (!out_en_reg[i] && do_write && wstrb_reg[0]
                             && wa == SQWT_OFS_OUT_LEVEL) begin
                    out_level_reg[i] <= wdata_reg[i];
                end
            end
        end
    end

    // Sticky interrupt status, cleared by reading; a new event wins over the clear
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~stat_clear) | ch_irq;
        end
    end
endmodule : sqwt_unit

// *** tb/sqwt_pin_probe.sv ***
// Pin probe: the logic fed by one timer output; times its half periods.
// Assumes the pin is a registered level in the CLK_SYS domain.
`timescale 1ns/1ps
module sqwt_pin_probe (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Observed pin
    input wire logic pin,
    // Last half period in cycles
    output int half
);
    logic prev;
    int run;
    // The pin reaches this logic only once its port path is routed
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b0;
            run <= 0;
            half <= 0;
        end else begin
            prev <= pin;
            if (pin != prev) begin
                half <= run + 1;
                run <= 0;
            end else begin
                run <= run + 1;
            end
        end
    end
endmodule : sqwt_pin_probe

// *** tb/sqwt_unit_checker.sv ***
// Checker: bus handshakes, clock gating, stop freeze, interrupt masking.
// Assumes the master offers write address and data in the same cycle.
`timescale 1ns/1ps
module sqwt_unit_checker
    import sqwt_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Bus
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    // Outputs
    input wire logic [SQWT_NCH-1:0] TIMER_OUT,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    wire logic wr_hs = AWVALID && AWREADY && WVALID && WREADY;
    wire logic stop_all = wr_hs && AWADDR == SQWT_OFS_STOP && WDATA[7:0] == 8'hFF;
    logic en_seen;
    logic mask_zero;
    logic [1:0] quiet;
    logic [7:0] ar_q;
    // Quiet counts two cycles past a full stop, so a write still landing is excused
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            en_seen <= 1'b0;
            mask_zero <= 1'b1;
            quiet <= 2'h0;
            ar_q <= 8'h00;
        end else begin
            if (wr_hs && AWADDR == SQWT_OFS_PERIPH_EN && WDATA[0]) en_seen <= 1'b1;
            if (wr_hs && AWADDR == SQWT_OFS_IRQ_MASK) mask_zero <= WDATA[7:0] == 8'h00;
            if (wr_hs) quiet <= stop_all ? 2'h1 : 2'h0;
            else if (quiet != 2'h0 && quiet != 2'h3) quiet <= quiet + 2'h1;
            if (ARVALID && ARREADY) ar_q <= ARADDR;
        end
    end
    chk_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    chk_rdata_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    chk_read_latency: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    chk_write_refused: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken during response");
    chk_read_refused: assert property (RVALID |-> !ARREADY)
        else $error("read taken during response");
    chk_unmapped_read: assert property ($rose(RVALID) && ar_q inside {[8'h20:8'h3F]}
        |-> RRESP == SQWT_RESP_SLVERR && RDATA == 32'h0000_0000)
        else $error("unmapped read not refused");
    chk_clock_gate: assert property (!en_seen |-> !IRQ)
        else $error("interrupt before clock supply");
    chk_stop_freeze: assert property (quiet == 2'h3 |-> $stable(TIMER_OUT))
        else $error("output moved after stop");
    chk_mask_irq: assert property (mask_zero && $past(mask_zero) && $past(mask_zero, 2) |-> !IRQ)
        else $error("masked interrupt raised");
    cover property ($rose(IRQ));
    cover property ($changed(TIMER_OUT[5]));
    cover property ($rose(RVALID) && RRESP == SQWT_RESP_SLVERR);
endmodule : sqwt_unit_checker

// *** tb/sqwt_unit_tb.sv ***
// Bench for the timer unit: AXI4-Lite master tasks, one task per scenario.
// Assumes CLK_SYS at 10 MHz and the alternate count strobes driven here.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module sqwt_unit_tb
    import sqwt_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sub_tick, low_tick, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr, araddr, tout;
    logic [31:0] wdata, rdata, rdv;
    logic [1:0] bresp, rresp, rsp;
    logic [3:0] wstrb = 4'hF;
    int fails = 0;
    int comparisons = 0;
    int half;
    sqwt_unit dut (.CLK_SYS(clk), .NRST(nrst), .SUB_TICK(sub_tick), .LOW_TICK(low_tick),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .TIMER_OUT(tout), .IRQ(irq));
    sqwt_pin_probe u_probe (.clk(clk), .nrst(nrst), .pin(tout[0]), .half(half));
    always #50 clk = ~clk;
    // Ready is raised late on purpose so the slave must hold its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        int n;
        b_t = 1'b0;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!b_t && n < 50) begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            rsp = bresp;
            n++;
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            bready <= !b_t && n >= 3;
        end
        if (!b_t) fails++;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ar_t, r_t;
        int n;
        r_t = 1'b0;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        while (!r_t && n < 50) begin
            @(negedge clk);
            ar_t = arvalid && arready;
            r_t = rvalid && rready;
            rdv = rdata;
            rsp = rresp;
            n++;
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
            rready <= !r_t && n >= 2;
        end
        if (!r_t) fails++;
    endtask : rd
    task automatic pulse(input logic sub);
        @(posedge clk);
        if (sub) sub_tick <= 1'b1;
        else low_tick <= 1'b1;
        @(posedge clk);
        sub_tick <= 1'b0;
        low_tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic t_gate;
        wr(SQWT_OFS_START, 32'h0000_0001);
        rd(SQWT_OFS_ENABLED);
        `CHK(rdv, 32'h0000_0000);
        wr(SQWT_OFS_PERIPH_EN, 32'h0000_0001);
        wr(SQWT_OFS_START, 32'h0000_00FF);
        rd(SQWT_OFS_ENABLED);
        `CHK(rdv, 32'h0000_00FF);
        wr(SQWT_OFS_START, 32'h0000_0000);
        rd(SQWT_OFS_ENABLED);
        `CHK(rdv, 32'h0000_00FF);
        wr(SQWT_OFS_STOP, 32'h0000_00FF);
        rd(SQWT_OFS_ENABLED);
        `CHK(rdv, 32'h0000_0000);
        $display("t_gate done");
    endtask : t_gate
    task automatic t_level;
        wr(SQWT_OFS_OUT_LEVEL, 32'h0000_0001);
        `CHK(tout, 8'h01);
        wr(SQWT_OFS_OUT_EN, 32'h0000_0037);
        wr(SQWT_OFS_OUT_LEVEL, 32'h0000_0000);
        `CHK(tout, 8'h01);
        $display("t_level done");
    endtask : t_level
    task automatic t_wave;
        wr(8'h44, 32'h0000_0004);
        wr(SQWT_OFS_START, 32'h0000_0001);
        `CHK(tout[0], 1'b1);
        repeat (40) @(posedge clk);
        `CHK(half, 5);
        wr(SQWT_OFS_STOP, 32'h0000_0001);
        wr(8'h40, 32'h0000_0100);
        wr(8'h44, 32'h0000_0002);
        wr(SQWT_OFS_START, 32'h0000_0001);
        repeat (60) @(posedge clk);
        `CHK(half, 6);
        wr(8'h50, 32'h0000_0F01);
        wr(8'h54, 32'h0000_FFFF);
        wr(8'h60, 32'h0000_0F00);
        wr(8'h64, 32'h0000_0123);
        rd(SQWT_OFS_IRQ_STAT);
        wr(SQWT_OFS_START, 32'h0000_0006);
        @(negedge clk);
        `CHK(tout[1], 1'b1);
        `CHK(tout[2], 1'b0);
        rd(SQWT_OFS_IRQ_STAT);
        `CHK(rdv[2:1], 2'h1);
        rd(8'h68);
        `CHK(rdv, 32'h0000_0123);
        rd(8'h68);
        `CHK(rdv, 32'h0000_0123);
        rd(SQWT_OFS_ENABLED);
        `CHK(rdv[2:0], 3'h7);
        $display("t_wave done");
    endtask : t_wave
    task automatic t_alt;
        logic [7:0] t0;
        wr(8'h80, 32'h0000_0F10);
        wr(8'h90, 32'h0000_0F10);
        wr(SQWT_OFS_START, 32'h0000_0030);
        t0 = tout;
        repeat (3) pulse(1'b1);
        `CHK(tout[5:4], t0[5:4] ^ 2'h2);
        wr(SQWT_OFS_STOP, 32'h0000_0020);
        wr(8'h90, 32'h0000_0F20);
        wr(SQWT_OFS_START, 32'h0000_0020);
        t0 = tout;
        pulse(1'b0);
        pulse(1'b1);
        `CHK(tout[5], ~t0[5]);
        $display("t_alt done");
    endtask : t_alt
    task automatic t_irq;
        int n;
        n = 0;
        wr(SQWT_OFS_IRQ_MASK, 32'h0000_0001);
        while (irq !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        `CHK(irq, 1'b1);
        wr(SQWT_OFS_IRQ_MASK, 32'h0000_0000);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0);
        wr(SQWT_OFS_STOP, 32'h0000_00FF);
        rd(SQWT_OFS_IRQ_STAT);
        rd(SQWT_OFS_IRQ_STAT);
        `CHK(rdv, 32'h0000_0000);
        wr(SQWT_OFS_IRQ_MASK, 32'h0000_00FF);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_map;
        rd(SQWT_OFS_OUT_EN);
        `CHK(rsp, SQWT_RESP_OKAY);
        `CHK(rdv, 32'h0000_0037);
        rd(8'h20);
        `CHK(rsp, SQWT_RESP_SLVERR);
        `CHK(rdv, 32'h0000_0000);
        wr(8'h24, 32'h0000_0001);
        `CHK(rsp, SQWT_RESP_SLVERR);
        // A write with no byte lane enabled is answered but changes nothing
        wstrb <= 4'h0;
        wr(SQWT_OFS_IRQ_MASK, 32'h0000_0001);
        `CHK(rsp, SQWT_RESP_OKAY);
        wstrb <= 4'hF;
        rd(SQWT_OFS_IRQ_MASK);
        `CHK(rdv, 32'h0000_00FF);
        $display("t_map done");
    endtask : t_map
    task automatic t_reset;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        `CHK(tout, 8'h00);
        `CHK(irq, 1'b0);
        rd(8'h48);
        `CHK(rdv, {16'h0000, SQWT_RST_COUNT});
        $display("t_reset done");
    endtask : t_reset
    task automatic conclude;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial begin
        {sub_tick, low_tick, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0000_0000_0000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_gate;
        t_level;
        t_wave;
        t_alt;
        t_irq;
        t_map;
        t_reset;
        conclude;
    end
    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude;
    end
endmodule : sqwt_unit_tb
bind sqwt_unit sqwt_unit_checker u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TIMER_OUT(TIMER_OUT), .IRQ(IRQ));
